// *** srb_host_model.sv ***
// Purpose: Host controller model driving the framed serial link
// Assumes: Link clock idles high, eight system clocks per link period
// Notes:   Command bits change while link clock high, reply taken after fall
`timescale 1ns/1ps
module srb_host_model (
  input  wire logic CLK,
  output logic      SCLK,
  output logic      SYNC_N,
  output logic      SDI,
  input  wire logic SDO,
  input  wire logic SDO_OE
);
  // Idle link at time zero
  initial begin
    SCLK = 1'b1;
    SYNC_N = 1'b1;
    SDI = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // One frame of nb bits, MSB first, zero check byte after the command;
  // reply sampled one cycle after each fall, released line reads inverted
  task automatic xfer(input logic [23:0] cmd, output logic [23:0] rsp, output logic oe,
                      input int nb = 24);
    oe = 1'b0;
    SYNC_N <= 1'b0;
    hold(8);
    for (int i = 0; i < nb; i++) begin
      SDI <= (i < 24) ? cmd[23 - i] : 1'b0;
      hold(4);
      SCLK <= 1'b0;
      hold(1);
      if (i < 24) begin
        rsp[23 - i] = SDO_OE ? SDO : ~SDO;
      end
      oe = oe | SDO_OE;
      hold(3);
      SCLK <= 1'b1;
    end
    hold(4);
    SYNC_N <= 1'b1;
    SDI <= ~SDI; // Released line shows no stale level
    hold(20);
  endtask
endmodule

// *** srb_pkg.sv ***
// Purpose: Shared constants and types for the serial readback and bring-up block
// Assumes: 50 MHz system clock; 5-bit register addresses; 16-bit register data
// Notes:   Delay counts are derived from times in microseconds and the clock rate
package srb_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CAL_REFRESH_US  = 500;
  localparam int unsigned XFER_WAIT_US    = 300;
  localparam int unsigned CAL_REFRESH_CYC = (CLK_HZ / 1_000_000) * CAL_REFRESH_US;
  localparam int unsigned XFER_WAIT_CYC   = (CLK_HZ / 1_000_000) * XFER_WAIT_US;

  ////////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [4:0] ADR_NOP      = 5'h00;
  localparam logic [4:0] ADR_DAC_OUT  = 5'h02;
  localparam logic [4:0] ADR_SW_LOAD  = 5'h07;
  localparam logic [4:0] ADR_KEY      = 5'h08;
  localparam logic [4:0] ADR_SW_ONE   = 5'h0b;
  localparam logic [4:0] ADR_SW_TWO   = 5'h0c;
  localparam logic [4:0] ADR_RSV_A    = 5'h0d;
  localparam logic [4:0] ADR_RSV_B    = 5'h0e;
  localparam logic [4:0] ADR_LAST_CFG = 5'h12;
  localparam logic [4:0] ADR_RB_SEL   = 5'h13;
  localparam logic [4:0] ADR_DIAG     = 5'h14;
  localparam logic [4:0] ADR_STATUS   = 5'h16;

  ////////////////////////////////////////////////////////////////////////////////
  // Keys, fields and frame figures
  localparam logic [15:0] KEY_CAL_REFRESH = 16'hfcba;
  localparam logic [15:0] KEY_LOCK        = 16'h4765;
  localparam int unsigned RB_MODE_HI      = 9;
  localparam int unsigned RB_MODE_LO      = 8;
  localparam int unsigned DIAG_RESET_BIT  = 13;
  localparam int unsigned DIAG_CAL_BIT    = 15;
  localparam int unsigned BUSY3_BIT       = 12;
  localparam logic [1:0]  SYNC_PATTERN    = 2'b10;
  localparam logic [5:0]  FRAME_SHORT     = 6'h18;
  localparam logic [5:0]  FRAME_LONG      = 6'h20;
  localparam logic [5:0]  FRAME_CNT_MAX   = 6'h3f;

  typedef enum logic [1:0] {
    RB_TWO_STAGE = 2'b00,
    RB_AUTO      = 2'b01,
    RB_SHARED    = 2'b10,
    RB_ECHO      = 2'b11
  } srb_mode_e;

  typedef enum logic [1:0] {
    FR_IDLE   = 2'b00,
    FR_ACTIVE = 2'b01,
    FR_DONE   = 2'b11
  } srb_frame_e;

  // Power-on contents of each stored register
  function automatic logic [15:0] srb_reset_value(input logic [4:0] a);
    case (a)
      5'h04:   srb_reset_value = 16'hffff;
      5'h05:   srb_reset_value = 16'h8000;
      5'h06:   srb_reset_value = 16'h0c00;
      5'h09:   srb_reset_value = 16'h0204;
      5'h0a:   srb_reset_value = 16'h0200;
      5'h0c:   srb_reset_value = 16'h0100;
      5'h0f:   srb_reset_value = 16'h0009;
      5'h10:   srb_reset_value = 16'h005d;
      default: srb_reset_value = 16'h0000;
    endcase
  endfunction

  // Addresses whose data is held in the local register file
  function automatic logic srb_writable(input logic [4:0] a);
    srb_writable = (a != ADR_NOP) && (a <= ADR_LAST_CFG) && (a != ADR_DAC_OUT) &&
                   (a != ADR_SW_LOAD) && (a != ADR_KEY) && (a != ADR_RSV_A) &&
                   (a != ADR_RSV_B);
  endfunction

endpackage

// *** srb_readback_props.sv ***
// Purpose: Link-side checks on the serial readback block
// Assumes: One clock domain; reset synchronous and active low
// Notes:   Sees only the top-level ports of the block
`timescale 1ns/1ps
module srb_readback_props
  import srb_pkg::*;
#(
  parameter int unsigned CAL_REFRESH_CYCLES = CAL_REFRESH_CYC,
  parameter int unsigned XFER_WAIT_CYCLES   = XFER_WAIT_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SCLK,
  input wire logic SYNC_N,
  input wire logic SDO,
  input wire logic SDO_OE
);
  logic [3:0] idle_q;
  logic [3:0] idle_d;

  ////////////////////////////////////////////////////////////////////
  // Saturating count of cycles with frame select high
  always_comb begin
    idle_d = SYNC_N ? ((idle_q == 4'hf) ? idle_q : idle_q + 4'h1) : 4'h0;
  end
  always_ff @(posedge CLK) begin
    idle_q <= RST_N ? idle_d : 4'h0;
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////
  // Output enable follows the frame
  a_oe_idle_off: assert property (SYNC_N [*6] |-> !SDO_OE)
    else $error("output enabled between frames");
  a_oe_idle_cnt: assert property (SDO_OE |-> idle_q < 4'h6)
    else $error("output enable outlived the frame");
  a_oe_in_frame: assert property ($rose(SDO_OE) |-> !SYNC_N)
    else $error("output enabled outside a frame");
  a_oe_drop_end: assert property ($rose(SYNC_N) |-> ##[1:6] !SDO_OE)
    else $error("output enable not released after frame");
  a_oe_at_start: assert property ($rose(SDO_OE) |-> $past(SYNC_N, 6))
    else $error("reply started late in the frame");
  a_oe_holds_on: assert property ((!SYNC_N [*5]) ##0 $past(SDO_OE) |-> SDO_OE)
    else $error("reply dropped in mid frame");
  a_sdo_steady: assert property ((SDO_OE && $past(SDO_OE) && !SCLK) [*3] |-> $stable(SDO))
    else $error("reply bit moved while link clock low");
  a_reset_quiet: assert property (disable iff (1'b0) !RST_N |=> !SDO_OE && !SDO)
    else $error("reply driven during reset");

  c_reply: cover property ($rose(SDO_OE));
  c_one_bit: cover property (SDO_OE && SDO);
  c_frame: cover property ($fell(SYNC_N) ##[1:8] SDO_OE);
endmodule

// *** srb_serial_readback.sv ***
// Purpose: Serial link slave with readback modes, key commands and bring-up status
// Assumes: SCLK idles high; SDI sampled on SCLK fall, SDO advanced on SCLK rise
// Notes:   Link pins are oversampled by CLK; CRC byte is not checked and returns zero
`timescale 1ns/1ps

// Operation
// - Select register, then no-op frame returns it
// - Readback word: 10, fault, address, data
// - New select in second frame pipelines reads
// - Top two readback bits are binary 10
// - Auto mode returns status every frame
// - Status word carries flags, channel, result
// - Status follows each monitor sequencer result
// - Shared mode drives only after valid write
// - Echo mode alternates status and last command
// - Refresh key marks calibration unloaded meanwhile
// - Write one clears the reset seen flag
// - Switcher setup write holds transfer busy
// - Lock key protects user configuration space
// - Four readback behaviours chosen by select register
// - Status keeps last completed conversion, busy flag
module srb_serial_readback
  import srb_pkg::*;
#(
  parameter int unsigned CAL_REFRESH_CYCLES = CAL_REFRESH_CYC,
  parameter int unsigned XFER_WAIT_CYCLES   = XFER_WAIT_CYC,
  parameter logic [15:0] UNLOCK_KEY         = 16'h0001
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        SCLK,
  input  wire logic        SYNC_N,
  input  wire logic        SDI,
  output logic             SDO,
  output logic             SDO_OE,
  input  wire logic        FAULT_N,
  input  wire logic [1:0]  ADDR_PINS,
  input  wire logic        CRC_ENABLE,
  input  wire logic        DIGITAL_CHECK_SUMMARY,
  input  wire logic        ANALOG_CHECK_SUMMARY,
  input  wire logic        TIMEOUT_MONITOR_STATE,
  input  wire logic        MON_BUSY,
  input  wire logic        MON_DONE,
  input  wire logic [4:0]  MONITOR_CHANNEL,
  input  wire logic [11:0] MON_RESULT
);

  localparam int unsigned CNT_MAX = (CAL_REFRESH_CYCLES > XFER_WAIT_CYCLES) ?
                                    CAL_REFRESH_CYCLES : XFER_WAIT_CYCLES;
  localparam int unsigned CNT_W   = $clog2(CNT_MAX + 1);

  if (CAL_REFRESH_CYCLES < 1 || XFER_WAIT_CYCLES < 1) begin : g_chk
    $error("Delay counts must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage 0 feeds only stage 1
  logic [2:0] sclk_s;
  logic [2:0] sync_s;
  logic [1:0] sdi_s;
  logic [1:0] fault_s;
  logic [1:0] ad0_s;
  logic [1:0] ad1_s;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sclk_s  <= 3'h7;
      sync_s  <= 3'h7;
      sdi_s   <= 2'h0;
      fault_s <= 2'h3;
      ad0_s   <= 2'h0;
      ad1_s   <= 2'h0;
    end else begin
      sclk_s  <= {sclk_s[1:0], SCLK};
      sync_s  <= {sync_s[1:0], SYNC_N};
      sdi_s   <= {sdi_s[0], SDI};
      fault_s <= {fault_s[0], FAULT_N};
      ad0_s   <= {ad0_s[0], ADDR_PINS[0]};
      ad1_s   <= {ad1_s[0], ADDR_PINS[1]};
    end
  end

  // Edge detection on the settled stages
  logic sclk_fall;
  logic sclk_rise;
  logic frame_start;
  logic frame_end;
  logic fault_bit;

  assign sclk_fall   = sclk_s[2] & ~sclk_s[1];
  assign sclk_rise   = ~sclk_s[2] & sclk_s[1];
  assign frame_start = sync_s[2] & ~sync_s[1];
  assign frame_end   = ~sync_s[2] & sync_s[1];
  assign fault_bit   = ~fault_s[1];

  ////////////////////////////////////////////////////////////////////////////////
  // State declarations
  srb_frame_e  st_q, st_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [31:0] shin_q, shin_d;
  logic [31:0] out_q, out_d;
  logic        sdo_q, sdo_d;
  logic        oe_q, oe_d;
  logic        echo_ph_q, echo_ph_d;
  logic        wr_flag_q, wr_flag_d;
  logic [23:0] last_cmd_q, last_cmd_d;

  logic [15:0] mem_q [32];
  logic [15:0] mem_d [32];
  logic [15:0] rb_q, rb_d;
  logic        lock_q, lock_d;
  logic        cal_unl_q, cal_unl_d;
  logic        rst_seen_q, rst_seen_d;
  logic [CNT_W-1:0] cal_cnt_q, cal_cnt_d;
  logic [CNT_W-1:0] busy_cnt_q, busy_cnt_d;
  logic [4:0]  mon_ch_q, mon_ch_d;
  logic [11:0] mon_res_q, mon_res_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame decode shared by link and register logic
  logic        len_ok;
  logic [23:0] cmd;
  logic        cmd_ok;
  logic        cmd_stb;
  logic [4:0]  cmd_adr;
  logic [15:0] cmd_dat;
  srb_mode_e   mode;
  logic [4:0]  tgt;

  assign len_ok  = (cnt_q == FRAME_LONG) || (!CRC_ENABLE && cnt_q == FRAME_SHORT);
  assign cmd     = (cnt_q == FRAME_LONG) ? shin_q[31:8] : shin_q[23:0];
  assign cmd_ok  = len_ok && (cmd[23] == ~cmd[22]) && (cmd[22:21] == {ad1_s[1], ad0_s[1]});
  assign cmd_stb = (st_q == FR_DONE);
  assign cmd_adr = cmd[20:16];
  assign cmd_dat = cmd[15:0];
  assign mode    = srb_mode_e'(rb_q[RB_MODE_HI:RB_MODE_LO]);
  assign tgt     = rb_q[4:0];

  // Status word and selected register contents
  logic [23:0] status_w;
  logic [15:0] rd_data;
  logic        busy3;

  assign busy3    = (busy_cnt_q != '0);
  assign status_w = {1'b0, fault_bit, DIGITAL_CHECK_SUMMARY, ANALOG_CHECK_SUMMARY,
                     TIMEOUT_MONITOR_STATE, MON_BUSY, 1'b0, mon_ch_q, mon_res_q};

  always_comb begin
    rd_data = 16'h0000;
    if (tgt == ADR_RB_SEL) begin
      rd_data = rb_q;
    end else if (tgt == ADR_DIAG) begin
      rd_data[DIAG_CAL_BIT]   = cal_unl_q;
      rd_data[DIAG_RESET_BIT] = rst_seen_q;
    end else if (tgt == ADR_STATUS) begin
      rd_data = status_w[15:0];
    end else if (tgt == ADR_SW_TWO) begin
      rd_data            = mem_q[tgt];
      rd_data[BUSY3_BIT] = busy3;
    end else if (srb_writable(tgt)) begin
      rd_data = mem_q[tgt];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link next state: frame tracking, input shift, output word
  logic [23:0] word;

  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    shin_d     = shin_q;
    out_d      = out_q;
    sdo_d      = sdo_q;
    oe_d       = oe_q;
    echo_ph_d  = echo_ph_q;
    wr_flag_d  = wr_flag_q;
    last_cmd_d = last_cmd_q;
    word       = {SYNC_PATTERN, fault_bit, tgt, rd_data};
    case (mode)
      RB_AUTO:   word = status_w;
      RB_SHARED: word = status_w;
      RB_ECHO:   word = echo_ph_q ? last_cmd_q : status_w;
      default:   word = {SYNC_PATTERN, fault_bit, tgt, rd_data};
    endcase
    case (st_q)
      FR_IDLE: begin
        oe_d = 1'b0;
        if (frame_start) begin
          st_d      = FR_ACTIVE;
          cnt_d     = 6'h00;
          out_d     = {word, 8'h00};
          sdo_d     = word[23];
          oe_d      = (mode != RB_SHARED) || wr_flag_q;
          wr_flag_d = 1'b0;
          if (mode == RB_ECHO) begin
            echo_ph_d = ~echo_ph_q;
          end
        end
      end
      FR_ACTIVE: begin
        if (frame_end) begin
          st_d = FR_DONE;
          oe_d = 1'b0;
        end else begin
          if (sclk_fall) begin
            shin_d = {shin_q[30:0], sdi_s[1]};
            if (cnt_q != FRAME_CNT_MAX) begin
              cnt_d = cnt_q + 6'h01;
            end
          end
          if (sclk_rise) begin
            out_d = {out_q[30:0], 1'b0};
            sdo_d = out_q[30];
          end
        end
      end
      FR_DONE: begin
        st_d = FR_IDLE;
        if (cmd_ok) begin
          wr_flag_d  = 1'b1;
          last_cmd_d = cmd;
        end
      end
      default: st_d = FR_IDLE;
    endcase
  end

  // Link registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_q       <= FR_IDLE;
      cnt_q      <= 6'h00;
      shin_q     <= 32'h0000_0000;
      out_q      <= 32'h0000_0000;
      sdo_q      <= 1'b0;
      oe_q       <= 1'b0;
      echo_ph_q  <= 1'b0;
      wr_flag_q  <= 1'b0;
      last_cmd_q <= 24'h00_0000;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      shin_q     <= shin_d;
      out_q      <= out_d;
      sdo_q      <= sdo_d;
      oe_q       <= oe_d;
      echo_ph_q  <= echo_ph_d;
      wr_flag_q  <= wr_flag_d;
      last_cmd_q <= last_cmd_d;
    end
  end

  assign SDO    = sdo_q;
  assign SDO_OE = oe_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file next state: writes, keys, timers, monitor capture
  always_comb begin
    mem_d      = mem_q;
    rb_d       = rb_q;
    lock_d     = lock_q;
    cal_unl_d  = cal_unl_q;
    rst_seen_d = rst_seen_q;
    cal_cnt_d  = cal_cnt_q;
    busy_cnt_d = busy_cnt_q;
    mon_ch_d   = mon_ch_q;
    mon_res_d  = mon_res_q;
    if (MON_DONE) begin
      mon_ch_d  = MONITOR_CHANNEL;
      mon_res_d = MON_RESULT;
    end
    if (busy_cnt_q != '0) begin
      busy_cnt_d = busy_cnt_q - 1'b1;
    end
    if (cal_cnt_q != '0) begin
      cal_cnt_d = cal_cnt_q - 1'b1;
      if (cal_cnt_q == CNT_W'(1)) begin
        cal_unl_d = 1'b0;
      end
    end
    if (cmd_stb && cmd_ok) begin
      if (cmd_adr == ADR_KEY) begin
        if (cmd_dat == KEY_CAL_REFRESH) begin
          cal_cnt_d = CNT_W'(CAL_REFRESH_CYCLES);
          cal_unl_d = 1'b1;
        end else if (cmd_dat == KEY_LOCK) begin
          lock_d = 1'b1;
        end else if (cmd_dat == UNLOCK_KEY) begin
          lock_d = 1'b0;
        end
      end else if (cmd_adr == ADR_DIAG) begin
        if (cmd_dat[DIAG_RESET_BIT]) begin
          rst_seen_d = 1'b0;
        end
      end else if (cmd_adr == ADR_RB_SEL) begin
        rb_d = cmd_dat;
      end else if (!lock_q && srb_writable(cmd_adr)) begin
        mem_d[cmd_adr] = cmd_dat;
        if (cmd_adr == ADR_SW_ONE || cmd_adr == ADR_SW_TWO) begin
          busy_cnt_d = CNT_W'(XFER_WAIT_CYCLES);
        end
      end
    end
  end

  // Register file registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < 32; i++) begin
        mem_q[i] <= srb_reset_value(5'(i));
      end
      rb_q       <= 16'h0000;
      lock_q     <= 1'b0;
      cal_unl_q  <= 1'b1;
      rst_seen_q <= 1'b1;
      cal_cnt_q  <= '0;
      busy_cnt_q <= '0;
      mon_ch_q   <= 5'h00;
      mon_res_q  <= 12'h000;
    end else begin
      mem_q      <= mem_d;
      rb_q       <= rb_d;
      lock_q     <= lock_d;
      cal_unl_q  <= cal_unl_d;
      rst_seen_q <= rst_seen_d;
      cal_cnt_q  <= cal_cnt_d;
      busy_cnt_q <= busy_cnt_d;
      mon_ch_q   <= mon_ch_d;
      mon_res_q  <= mon_res_d;
    end
  end

endmodule

// *** testbench.sv ***
// Purpose: Self-checking bench for the serial readback block
// Assumes: Address straps 00, frame check off except in one test
// Notes:   Long waits shortened through the delay parameters
`timescale 1ns/1ps
module testbench;
  import srb_pkg::*;
  localparam int unsigned WAITC = 1000;
  localparam logic [15:0] OUT_ON = 16'h0040; // Output enable bit, arbitrary for the bench
  logic        clk, rst_n, sclk, sync_n, sdi, sdo, sdo_oe, oe, crc_en;
  logic [15:0] cfg;
  int          nb;
  logic        fault_n, dig, ana, wdt, mon_busy, mon_done;
  logic [4:0]  mon_ch, ch_x, a;
  logic [11:0] mon_res, res_x;
  logic [15:0] d;
  logic [23:0] rsp;
  int          num_errors, comparisons, seed;
  logic [4:0]  ra [9] = '{5'h14, 5'h04, 5'h05, 5'h06, 5'h09, 5'h0a, 5'h0c, 5'h0f, 5'h10};
  logic [15:0] rv [9] = '{16'ha000, 16'hffff, 16'h8000, 16'h0c00, 16'h0204, 16'h0200,
                          16'h0100, 16'h0009, 16'h005d};

  srb_serial_readback #(.CAL_REFRESH_CYCLES(WAITC), .XFER_WAIT_CYCLES(WAITC))
    srb_serial_readback_i (.CLK(clk), .RST_N(rst_n), .SCLK(sclk), .SYNC_N(sync_n),
    .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .FAULT_N(fault_n), .ADDR_PINS(2'b00),
    .CRC_ENABLE(crc_en), .DIGITAL_CHECK_SUMMARY(dig), .ANALOG_CHECK_SUMMARY(ana),
    .TIMEOUT_MONITOR_STATE(wdt), .MON_BUSY(mon_busy), .MON_DONE(mon_done),
    .MONITOR_CHANNEL(mon_ch), .MON_RESULT(mon_res));
  srb_host_model host_i (.CLK(clk), .SCLK(sclk), .SYNC_N(sync_n), .SDI(sdi), .SDO(sdo),
    .SDO_OE(sdo_oe));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////
  // Expected words and bench tasks
  function automatic logic [23:0] cmd(input logic [4:0] ad, input logic [15:0] da);
    return {3'b100, ad, da};
  endfunction
  function automatic logic [23:0] rbw(input logic [4:0] ad, input logic [15:0] da);
    return {2'b10, ~fault_n, ad, da};
  endfunction
  function automatic logic [23:0] stw();
    return {1'b0, ~fault_n, dig, ana, wdt, mon_busy, 1'b0, ch_x, res_x};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: enable %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic send(input logic [4:0] ad, input logic [15:0] da);
    host_i.xfer(cmd(ad, da), rsp, oe, nb);
  endtask
  task automatic rd(input logic [4:0] ad, input logic [15:0] exp);
    send(ADR_RB_SEL, {11'h0, ad});
    send(ADR_NOP, 16'h0);
    check_word(rsp, rbw(ad, exp));
  endtask
  task automatic shake();
    @(posedge clk);
    {fault_n, dig, ana, wdt, mon_busy} <= 5'($urandom);
    tick(3);
  endtask
  task automatic conv();
    @(posedge clk);
    mon_ch <= 5'($urandom);
    mon_res <= 12'($urandom);
    mon_done <= 1'b1;
    @(posedge clk);
    mon_done <= 1'b0;
    ch_x = mon_ch;
    res_x = mon_res;
  endtask
  task automatic stop_test();
    $display("comparisons %0d, num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    num_errors = 0;
    comparisons = 0;
    seed = $urandom(87723);
    rst_n = 1'b0;
    {fault_n, dig, ana, wdt, mon_busy, mon_done} = 6'b100000;
    crc_en = 1'b0;
    nb = 24;
    {mon_ch, mon_res, ch_x, res_x, a, d} = '0;
    tick(16);
    rst_n <= 1'b1;
    tick(5000);
    shake();
    send(ADR_RB_SEL, {11'h0, ra[0]});
    for (int k = 1; k <= 9; k++) begin
      send(k < 9 ? ADR_RB_SEL : ADR_NOP, k < 9 ? {11'h0, ra[k % 9]} : 16'h0);
      check_word(rsp, rbw(ra[k-1], rv[k-1]));
    end
    $display("test power-on values done");
    for (int k = 0; k < 4; k++) begin
      d = 16'($urandom);
      a = k[0] ? 5'h11 : 5'h03;
      send(a, d);
      rd(a, d);
      send(ADR_KEY, KEY_LOCK);
      send(a, ~d);
      rd(a, d);
      send(ADR_KEY, 16'h0001);
    end
    $display("test write and lock done");
    // Frame check on: only 32-bit frames count, sync pattern leads the reply
    crc_en <= 1'b1;
    nb = 32;
    d = 16'($urandom);
    send(5'h03, d);
    rd(5'h03, d);
    nb = 24;
    send(5'h03, ~d);
    nb = 32;
    rd(5'h03, d);
    crc_en <= 1'b0;
    nb = 24;
    send(ADR_DAC_OUT, d);
    rd(ADR_DAC_OUT, 16'h0000);
    $display("test frame check done");
    send(ADR_KEY, KEY_CAL_REFRESH);
    tick(WAITC);
    rd(ADR_DIAG, 16'h2000);
    send(ADR_KEY, KEY_CAL_REFRESH);
    send(ADR_NOP, 16'h0);
    check_word(rsp, rbw(ADR_DIAG, 16'ha000));
    send(ADR_DIAG, 16'h2000);
    tick(WAITC);
    rd(ADR_DIAG, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      send(ADR_RB_SEL, {11'h0, ADR_SW_TWO});
      send(k[0] ? ADR_SW_ONE : ADR_SW_TWO, 16'h0100);
      send(ADR_NOP, 16'h0);
      check_word(rsp, rbw(ADR_SW_TWO, 16'h1100));
      tick(WAITC);
      rd(ADR_SW_TWO, 16'h0100);
    end
    $display("test diagnostics and busy done");
    send(ADR_RB_SEL, 16'h0100);
    for (int k = 0; k < 3; k++) begin
      conv();
      shake();
      send(ADR_NOP, 16'h0);
      check_word(rsp, stw());
    end
    send(ADR_RB_SEL, 16'h0200);
    send(ADR_NOP, 16'h0);
    check_flag(oe, 1'b1);
    check_word(rsp, stw());
    host_i.xfer(24'ha00000, rsp, oe);
    send(ADR_NOP, 16'h0);
    check_flag(oe, 1'b0);
    send(ADR_RB_SEL, 16'h0300);
    send(ADR_NOP, 16'h0);
    check_word(rsp, stw());
    send(ADR_NOP, 16'h0);
    check_word(rsp, cmd(ADR_NOP, 16'h0));
    send(ADR_RB_SEL, 16'h0300);
    check_word(rsp, stw());
    send(ADR_NOP, 16'h0);
    check_word(rsp, cmd(ADR_RB_SEL, 16'h0300));
    $display("test status modes done");
    // Mid-run reset, then the host bring-up and range change order
    rst_n <= 1'b0;
    tick(4);
    rst_n <= 1'b1;
    tick(5000);
    rd(ADR_DIAG, 16'ha000);
    send(ADR_KEY, KEY_CAL_REFRESH);
    tick(WAITC);
    send(ADR_DIAG, 16'h2000);
    d = 16'($urandom);
    cfg = 16'($urandom) & ~OUT_ON;
    send(5'h09, d);
    send(ADR_SW_TWO, d);
    tick(WAITC);
    send(ADR_SW_ONE, ~d);
    tick(WAITC);
    send(5'h06, cfg);
    tick(WAITC);
    send(5'h01, 16'h0000);
    send(5'h06, cfg | OUT_ON);
    send(5'h01, d);
    rd(5'h06, cfg | OUT_ON);
    rd(5'h09, d);
    rd(ADR_SW_TWO, d & ~(16'h0001 << BUSY3_BIT));
    send(5'h01, 16'h0000);
    send(5'h06, ~cfg & ~OUT_ON);
    tick(WAITC);
    send(5'h01, 16'h8000);
    send(5'h06, ~cfg | OUT_ON);
    send(5'h01, ~d);
    rd(5'h06, ~cfg | OUT_ON);
    rd(5'h01, ~d);
    rd(ADR_DIAG, 16'h0000);
    $display("test bring-up after reset done");
    stop_test();
  end

  // Watchdog against a hung run
  initial begin
    tick(80000);
    num_errors++;
    $display("unexpected at %0t: run did not finish", $time);
    stop_test();
  end
endmodule

bind srb_serial_readback srb_readback_props #(.CAL_REFRESH_CYCLES(CAL_REFRESH_CYCLES),
  .XFER_WAIT_CYCLES(XFER_WAIT_CYCLES)) srb_readback_props_i (.CLK(CLK), .RST_N(RST_N),
  .SCLK(SCLK), .SYNC_N(SYNC_N), .SDO(SDO), .SDO_OE(SDO_OE));
